// [rtl/uart_qstat_defs.vh]
// Purpose: Shared constants for the serial port status and shadow block
// Assumes: 8-bit register byte address, 32-bit register data
// Notes:   Definitions only
`ifndef UART_QSTAT_DEFS_VH
`define UART_QSTAT_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFF_DATA      8'h00
`define OFF_QCTRL     8'h08
`define OFF_MODEM     8'h10
`define OFF_TEST_EN   8'h70
`define OFF_TEST_WR   8'h78
`define OFF_STATUS    8'h7c
`define OFF_TX_LEVEL  8'h80
`define OFF_RX_LEVEL  8'h84
`define OFF_SWRST     8'h88
`define OFF_RTS_SHD   8'h8c
`define OFF_IRQ_STAT  8'ha0
`define OFF_IRQ_MASK  8'ha4

// ==========================================================
// Field positions
`define SWRST_TX_FLUSH  2
`define SWRST_RX_FLUSH  1
`define SWRST_PORT      0
`define QCTRL_TX_FLUSH  2
`define QCTRL_RX_FLUSH  1
`define MODEM_RTS       1
`define RTS_SHD_BIT     0
`define TEST_EN_BIT     0
`define STAT_RX_FULL    4
`define STAT_RX_NEMPTY  3
`define STAT_TX_EMPTY   2
`define STAT_TX_NFULL   1
`define STAT_BUSY       0
`define IRQ_RX_DONE     0
`define IRQ_TX_EMPTY    1
`define IRQ_RX_OVERRUN  2

// ==========================================================
// Widths and reset values
`define DATA_W          32
`define BYTE_W          8
`define IRQ_W           3
`define LEVEL_W         5
`define ZERO32          32'h0000_0000
`define RX_LINE_IDLE    1'b1
`define TX_EMPTY_RST    1'b1

`endif

// [rtl/sync_queue.v]
// Purpose: Synchronous byte queue with registered head data
// Assumes: Single clock, push and pop ignored when full or empty
// Notes:   LIMIT caps the fill at or below the array size
`timescale 1ns/1ps
module sync_queue #(
  parameter DW    = 8,
  parameter AW    = 4,
  parameter LIMIT = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // Control
  input  wire          push,
  input  wire [DW-1:0] wdata,
  input  wire          pop,
  input  wire          clr,
  // State
  output reg  [DW-1:0] rdata_q,
  output reg  [AW:0]   count_q,
  output wire          full,
  output wire          empty
);
  reg  [DW-1:0] mem [0:(1<<AW)-1];
  reg  [AW-1:0] wptr_q;
  reg  [AW-1:0] rptr_q;
  wire          do_push = push && !full && !clr;
  wire          do_pop  = pop && !empty && !clr;
  wire [AW-1:0] rptr_d  = clr ? {AW{1'b0}} :
                          (do_pop ? rptr_q + 1'b1 : rptr_q);
  wire [AW:0]   count_d = clr ? {(AW+1){1'b0}} :
                          count_q + {{AW{1'b0}}, do_push}
                                  - {{AW{1'b0}}, do_pop};
  wire [AW:0]   lim     = LIMIT[AW:0];

  assign full  = (count_q == lim);
  assign empty = (count_q == {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (do_push) begin
      mem[wptr_q] <= wdata;
    end
  end

  // Head bypass so a byte pushed into an empty queue reads at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q  <= {AW{1'b0}};
      rptr_q  <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      rdata_q <= {DW{1'b0}};
    end else begin
      wptr_q  <= clr ? {AW{1'b0}} : (do_push ? wptr_q + 1'b1 : wptr_q);
      rptr_q  <= rptr_d;
      count_q <= count_d;
      rdata_q <= (do_push && count_d == {{AW{1'b0}}, 1'b1}) ?
                 wdata : mem[rptr_d];
    end
  end
endmodule

// [rtl/rst_sync.v]
// Purpose: Reset bridge, asynchronous assert and clocked release
// Assumes: arst_n may be a gated combination of reset sources
// Notes:   Two stages before release reaches the port logic
`timescale 1ns/1ps
module rst_sync (
  // Clock and raw reset
  input  wire clk,
  input  wire arst_n,
  // Released reset
  output wire rst_n
);
  reg stage1_q;
  reg stage2_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end

  assign rst_n = stage2_q;
endmodule

// [rtl/uart_qstat.v]
// Purpose: Serial port with queue status, level, soft reset and shadows
// Assumes: Register port with one-cycle strobes, read data next cycle
// Notes:   8N1 framing, fixed bit period of BAUD_DIV clocks
//
// Functional notes
// - In queue test mode a written test byte enters the receive queue.
// - Test mode enable bit at 0x70; writes ignored without test option.
// - Queue status flags carry values only with the status option.
// - Status bit 4 is one when the receive queue is full.
// - Status bit 3 is one when the receive queue is not empty.
// - Status bit 2 is one when transmit queue empty; resets to one.
// - Status bit 1 is one when transmit queue not full; resets to one.
// - Status bit 0 is one while a serial transfer runs; resets zero.
// - Transmit level register shows transmit queue fill in five bits.
// - Receive level register shows receive queue fill, resets zero.
// - Soft reset bit 2 flushes transmit queue like queue control does.
// - Soft reset bit 1 flushes receive queue like queue control does.
// - Without queues both flush bits of soft reset are ignored.
// - Soft reset bit 0 resets the port one clock after the write, released on clock.
// - Shadow RTS bit 0 shares storage with modem control RTS bit.
`timescale 1ns/1ps
`include "uart_qstat_defs.vh"
module uart_qstat #(
  parameter QUEUE_BUILT  = 1,
  parameter QUEUE_STAT   = 1,
  parameter QUEUE_ACCESS = 1,
  parameter ADDR_W       = 4,
  parameter BAUD_DIV     = 16,
  parameter CW           = 16
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 arst_n,
  // Register port
  input  wire [7:0]           addr,
  input  wire [`DATA_W-1:0]   wr_data,
  input  wire                 wr_en,
  input  wire                 rd_en,
  output reg  [`DATA_W-1:0]   rd_data_q,
  // Serial line
  input  wire                 rxd,
  output reg                  txd_q,
  // Modem control
  output reg                  rts_n_q,
  // Interrupt
  output reg                  irq_q
);
  localparam DEPTH = QUEUE_BUILT != 0 ? (1 << ADDR_W) : 1;
  localparam [CW-1:0] DIV_CW    = BAUD_DIV[CW-1:0];
  localparam [CW-1:0] BIT_LAST  = DIV_CW - 1'b1;
  localparam [CW-1:0] HALF_LAST = (DIV_CW >> 1) - 1'b1;
  localparam [3:0]    TX_STOP   = 4'd9;
  localparam [2:0]    RX_LAST   = 3'd7;
  localparam [1:0]    RX_IDLE   = 2'd0;
  localparam [1:0]    RX_START  = 2'd1;
  localparam [1:0]    RX_DATA   = 2'd2;
  localparam [1:0]    RX_STOP   = 2'd3;

  // ==========================================================
  // Port reset
  reg  soft_q;
  wire core_rst_n;
  wire raw_rst_n = arst_n & ~soft_q;
  // Self-clearing request; the bridge below stretches it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_en && addr == `OFF_SWRST &&
                wr_data[`SWRST_PORT];
    end
  end

  rst_sync u_rst_sync (
    .clk    (clk),
    .arst_n (raw_rst_n),
    .rst_n  (core_rst_n)
  );

  // ==========================================================
  // Decode
  wire wr_data_reg = wr_en && addr == `OFF_DATA;
  wire wr_qctrl    = wr_en && addr == `OFF_QCTRL;
  wire wr_modem    = wr_en && addr == `OFF_MODEM;
  wire wr_test_en  = wr_en && addr == `OFF_TEST_EN;
  wire wr_test     = wr_en && addr == `OFF_TEST_WR;
  wire wr_swrst    = wr_en && addr == `OFF_SWRST;
  wire wr_rts_shd  = wr_en && addr == `OFF_RTS_SHD;
  wire wr_imask    = wr_en && addr == `OFF_IRQ_MASK;
  wire rd_data_reg = rd_en && addr == `OFF_DATA;
  wire rd_istat    = rd_en && addr == `OFF_IRQ_STAT;

  wire flush_tx = (QUEUE_BUILT != 0) &&
                  ((wr_swrst && wr_data[`SWRST_TX_FLUSH]) ||
                   (wr_qctrl && wr_data[`QCTRL_TX_FLUSH]));
  wire flush_rx = (QUEUE_BUILT != 0) &&
                  ((wr_swrst && wr_data[`SWRST_RX_FLUSH]) ||
                   (wr_qctrl && wr_data[`QCTRL_RX_FLUSH]));

  // ==========================================================
  // Control registers
  reg             test_en_q;
  reg             rts_q;
  reg [`IRQ_W-1:0] imask_q;
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      test_en_q <= 1'b0;
      rts_q     <= 1'b0;
      imask_q   <= {`IRQ_W{1'b0}};
      rts_n_q   <= 1'b1;
    end else begin
      if (wr_test_en && QUEUE_ACCESS != 0) begin
        test_en_q <= wr_data[`TEST_EN_BIT];
      end
      if (wr_modem) begin
        rts_q <= wr_data[`MODEM_RTS];
      end else if (wr_rts_shd) begin
        rts_q <= wr_data[`RTS_SHD_BIT];
      end
      if (wr_imask) begin
        imask_q <= wr_data[`IRQ_W-1:0];
      end
      rts_n_q <= ~rts_q;
    end
  end

  // ==========================================================
  // Queues
  wire [`BYTE_W-1:0] tx_head;
  wire [`BYTE_W-1:0] rx_head;
  wire [ADDR_W:0]    tx_count;
  wire [ADDR_W:0]    rx_count;
  wire               tx_full;
  wire               tx_empty;
  wire               rx_full;
  wire               rx_empty;
  reg                tx_busy_q;
  reg                rx_done_q;
  reg [`BYTE_W-1:0]  rx_sh_q;

  wire test_push = wr_test && test_en_q;
  wire rx_push   = test_push || rx_done_q;
  wire [`BYTE_W-1:0] rx_wdata = test_push ? wr_data[`BYTE_W-1:0] :
                                rx_sh_q;
  wire tx_pop    = !tx_busy_q && !tx_empty;
  wire rx_pop    = rd_data_reg && !rx_empty;
  sync_queue #(
    .DW    (`BYTE_W),
    .AW    (ADDR_W),
    .LIMIT (DEPTH)
  ) u_tx_queue (
    .clk     (clk),
    .rst_n   (core_rst_n),
    .push    (wr_data_reg),
    .wdata   (wr_data[`BYTE_W-1:0]),
    .pop     (tx_pop),
    .clr     (flush_tx),
    .rdata_q (tx_head),
    .count_q (tx_count),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  // Depth one stands in for the plain receive buffer
  sync_queue #(
    .DW    (`BYTE_W),
    .AW    (ADDR_W),
    .LIMIT (DEPTH)
  ) u_rx_queue (
    .clk     (clk),
    .rst_n   (core_rst_n),
    .push    (rx_push),
    .wdata   (rx_wdata),
    .pop     (rx_pop),
    .clr     (flush_rx),
    .rdata_q (rx_head),
    .count_q (rx_count),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  // ==========================================================
  // Transmitter
  reg [CW-1:0]     tx_cnt_q;
  reg [3:0]        tx_bit_q;
  reg [`BYTE_W:0]  tx_sh_q;
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= {CW{1'b0}};
      tx_bit_q  <= 4'd0;
      tx_sh_q   <= {(`BYTE_W+1){1'b1}};
      txd_q     <= 1'b1;
    end else if (!tx_busy_q) begin
      if (!tx_empty) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= {CW{1'b0}};
        tx_bit_q  <= 4'd0;
        tx_sh_q   <= {1'b1, tx_head};
        txd_q     <= 1'b0;
      end
    end else if (tx_cnt_q == BIT_LAST) begin
      tx_cnt_q <= {CW{1'b0}};
      if (tx_bit_q == TX_STOP) begin
        tx_busy_q <= 1'b0;
      end else begin
        txd_q    <= tx_sh_q[0];
        tx_sh_q  <= {1'b1, tx_sh_q[`BYTE_W:1]};
        tx_bit_q <= tx_bit_q + 4'd1;
      end
    end else begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Receive line synchroniser
  reg rx_s1_q;
  reg rx_s2_q;
  reg rx_s3_q;
  reg rx_line_q;
  // A level counts only once stages two and three agree
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rx_s1_q   <= `RX_LINE_IDLE;
      rx_s2_q   <= `RX_LINE_IDLE;
      rx_s3_q   <= `RX_LINE_IDLE;
      rx_line_q <= `RX_LINE_IDLE;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_line_q <= rx_s3_q;
      end
    end
  end

  // ==========================================================
  // Receiver
  reg [1:0]    rx_state_q;
  reg [CW-1:0] rx_cnt_q;
  reg [2:0]    rx_bit_q;
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= {CW{1'b0}};
      rx_bit_q   <= 3'd0;
      rx_sh_q    <= {`BYTE_W{1'b0}};
      rx_done_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= {CW{1'b0}};
          if (!rx_line_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_q == HALF_LAST) begin
            rx_cnt_q   <= {CW{1'b0}};
            rx_bit_q   <= 3'd0;
            // Short low pulse is noise, not a start bit
            rx_state_q <= rx_line_q ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q == BIT_LAST) begin
            rx_cnt_q <= {CW{1'b0}};
            rx_sh_q  <= {rx_line_q, rx_sh_q[`BYTE_W-1:1]};
            rx_bit_q <= rx_bit_q + 3'd1;
            if (rx_bit_q == RX_LAST) begin
              rx_state_q <= RX_STOP;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        RX_STOP: begin
          if (rx_cnt_q == BIT_LAST) begin
            rx_cnt_q   <= {CW{1'b0}};
            rx_state_q <= RX_IDLE;
            // Framing errors drop the byte
            rx_done_q  <= rx_line_q;
          end else begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  wire busy = tx_busy_q || rx_state_q != RX_IDLE;

  // ==========================================================
  // Interrupts
  reg  [`IRQ_W-1:0] istat_q;
  reg               tx_empty_q;
  wire [`IRQ_W-1:0] ievent;
  assign ievent[`IRQ_RX_DONE]    = rx_push && !rx_full && !flush_rx;
  assign ievent[`IRQ_TX_EMPTY]   = tx_empty && !tx_empty_q;
  assign ievent[`IRQ_RX_OVERRUN] = (rx_push && rx_full) ||
                                   (test_push && rx_done_q);

  // New events win over the clear of a status read
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      istat_q    <= {`IRQ_W{1'b0}};
      tx_empty_q <= `TX_EMPTY_RST;
      irq_q      <= 1'b0;
    end else begin
      istat_q    <= (rd_istat ? {`IRQ_W{1'b0}} : istat_q) | ievent;
      tx_empty_q <= tx_empty;
      irq_q      <= |(istat_q & imask_q);
    end
  end

  // ==========================================================
  // Read path
  reg  [`DATA_W-1:0] rd_mux;
  wire               stat_on = (QUEUE_STAT != 0);
  always @* begin
    rd_mux = `ZERO32;
    case (addr)
      `OFF_DATA:     rd_mux[`BYTE_W-1:0] = rx_head;
      `OFF_MODEM:    rd_mux[`MODEM_RTS]  = rts_q;
      `OFF_TEST_EN:  rd_mux[`TEST_EN_BIT] = test_en_q;
      `OFF_STATUS: begin
        rd_mux[`STAT_RX_FULL]   = stat_on && rx_full;
        rd_mux[`STAT_RX_NEMPTY] = stat_on && !rx_empty;
        rd_mux[`STAT_TX_EMPTY]  = stat_on && tx_empty;
        rd_mux[`STAT_TX_NFULL]  = stat_on && !tx_full;
        rd_mux[`STAT_BUSY]      = busy;
      end
      `OFF_TX_LEVEL: begin
        if (stat_on) begin
          rd_mux[`LEVEL_W-1:0] = tx_count;
        end
      end
      `OFF_RX_LEVEL: begin
        if (stat_on) begin
          rd_mux[`LEVEL_W-1:0] = rx_count;
        end
      end
      `OFF_RTS_SHD:  rd_mux[`RTS_SHD_BIT] = rts_q;
      `OFF_IRQ_STAT: rd_mux[`IRQ_W-1:0]  = istat_q;
      `OFF_IRQ_MASK: rd_mux[`IRQ_W-1:0]  = imask_q;
      default:       rd_mux = `ZERO32;
    endcase
  end

  // Only data and interrupt status reads change state
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rd_data_q <= `ZERO32;
    end else begin
      rd_data_q <= rd_en ? rd_mux : `ZERO32;
    end
  end
endmodule

// [bench/serial_peer.sv]
// Purpose: Remote serial port on the far end of the line
// Assumes: 8N1 framing, BIT_CYC clocks per bit, idle high
// Notes:   Captures one byte per frame seen on txd
`timescale 1ns/1ps
module serial_peer #(
  parameter BIT_CYC = 4
) (
  // Clock
  input  wire clk,
  // Serial line
  input  wire txd,
  output reg  rxd_q
);
  reg  [7:0] got_q;
  reg  [9:0] sh;
  integer    n;
  integer    k;

  // ========
  // Frame sender
  initial rxd_q = 1'b1;
  task send(input [7:0] b);
    begin
      sh = {1'b1, b, 1'b0};
      for (n = 0; n < 10; n = n + 1) begin
        rxd_q <= sh[n];
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  endtask

  // ========
  // Frame receiver, sampled mid bit
  initial begin
    got_q = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (k = 0; k < 8; k = k + 1) begin
        repeat (BIT_CYC) @(posedge clk);
        got_q[k] = txd;
      end
      // Skip into the stop bit before rearming
      repeat (BIT_CYC) @(posedge clk);
    end
  end
endmodule

// [bench/uart_qstat_chk.sv]
// Purpose: Port-level checks of the serial status block
// Assumes: Strobes one cycle, read data the cycle after
// Notes:   Bound to every uart_qstat instance
`timescale 1ns/1ps
module uart_qstat_chk (
  // Clock and reset
  input wire        clk,
  input wire        arst_n,
  // Register port
  input wire [7:0]  addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data_q,
  // Pins
  input wire        rxd,
  input wire        txd_q,
  input wire        rts_n_q,
  input wire        irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ========
  // Assertions
  property p_shd_wr;
    wr_en && addr == 8'h8c |-> ##2 rts_n_q == !$past(wr_data[0], 2);
  endproperty
  a_shd_wr: assert property (p_shd_wr) else $error("shadow rts");
  property p_mdm_wr;
    wr_en && addr == 8'h10 |-> ##2 rts_n_q == !$past(wr_data[1], 2);
  endproperty
  a_mdm_wr: assert property (p_mdm_wr) else $error("modem rts");
  property p_shd_rd;
    rd_en && addr == 8'h8c |=> rd_data_q == {31'h0000_0000, ~rts_n_q};
  endproperty
  a_shd_rd: assert property (p_shd_rd) else $error("rts read");
  property p_srr_rd;
    rd_en && addr == 8'h88 |=> rd_data_q == 32'h0000_0000;
  endproperty
  a_srr_rd: assert property (p_srr_rd) else $error("swrst read");
  property p_stat_rsv;
    rd_en && addr == 8'h7c |=> rd_data_q[31:5] == 27'h000_0000;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status hi");
  property p_lvl;
    rd_en && (addr == 8'h80 || addr == 8'h84) |=> rd_data_q <= 32'h0000_0010;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level range");
  property p_busy;
    rd_en && addr == 8'h7c && !txd_q |=> rd_data_q[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag");
  // Flush, one idle cycle, then the level read
  property p_txfl;
    wr_en && (addr == 8'h88 || addr == 8'h08) && wr_data[2]
      ##2 rd_en && addr == 8'h80 |=> rd_data_q == 32'h0000_0000;
  endproperty
  a_txfl: assert property (p_txfl) else $error("tx flush");
  property p_rxfl;
    wr_en && (addr == 8'h88 || addr == 8'h08) && wr_data[1]
      ##2 rd_en && addr == 8'h84 |=> rd_data_q == 32'h0000_0000;
  endproperty
  a_rxfl: assert property (p_rxfl) else $error("rx flush");
  property p_mask;
    wr_en && addr == 8'ha4 && wr_data[2:0] == 3'h0
      ##1 !(wr_en && addr == 8'ha4) |=> !irq_q;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");

  // ========
  // Coverage
  c_busy: cover property (rd_en && addr == 8'h7c && !txd_q);
  c_irq: cover property ($rose(irq_q));
  c_rts: cover property ($fell(rts_n_q));
endmodule

bind uart_qstat uart_qstat_chk uart_qstat_chk_inst (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .rxd(rxd),
  .txd_q(txd_q), .rts_n_q(rts_n_q), .irq_q(irq_q));

// [bench/testbench.sv]
// Purpose: Register-level tests of the serial status block
// Assumes: Default options, four clocks per serial bit
// Notes:   Ends through end_sim only
`timescale 1ns/1ps
module testbench;
  reg         clk;
  reg         arst_n;
  reg  [7:0]  addr;
  reg  [31:0] wr_data;
  reg         wr_en;
  reg         rd_en;
  wire [31:0] rd_data_q;
  wire        rxd;
  wire        txd_q;
  wire        rts_n_q;
  wire        irq_q;
  integer     fails;
  integer     samples_checked;
  integer     cyc;
  integer     i;

  uart_qstat #(.BAUD_DIV(4)) uart_qstat_inst (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .rxd(rxd),
    .txd_q(txd_q), .rts_n_q(rts_n_q), .irq_q(irq_q));
  serial_peer #(.BIT_CYC(4)) serial_peer_inst (
    .clk(clk), .txd(txd_q), .rxd_q(rxd));

  // ========
  // Clock, timeout and report
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      if (fails == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // ========
  // Register port
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data_q, exp);
    end
  endtask
  task pins(input [31:0] exp);
    begin
      repeat (2) @(posedge clk);
      #1;
      chk({30'h0000_0000, irq_q, rts_n_q}, exp);
    end
  endtask

  // ========
  // Main sequence
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h7c, 32'h0000_0006);
    rdc(8'h80, 32'h0000_0000);
    rdc(8'h84, 32'h0000_0000);
    rdc(8'h8c, 32'h0000_0000);
    rdc(8'h88, 32'h0000_0000);
    rdc(8'h44, 32'h0000_0000);
    // Test writes are dropped until the enable is set
    wr(8'h78, 32'h0000_0055);
    rdc(8'h84, 32'h0000_0000);
    wr(8'h70, 32'h0000_0001);
    rdc(8'h70, 32'h0000_0001);
    wr(8'h78, 32'hffff_ff10);
    rdc(8'h84, 32'h0000_0001);
    rdc(8'h7c, 32'h0000_000e);
    for (i = 1; i < 16; i = i + 1)
      wr(8'h78, 32'h0000_0010 + i);
    rdc(8'h84, 32'h0000_0010);
    rdc(8'h7c, 32'h0000_001e);
    rdc(8'h7c, 32'h0000_001e);
    wr(8'ha4, 32'h0000_0007);
    rdc(8'ha4, 32'h0000_0007);
    wr(8'h78, 32'h0000_0099);
    pins(32'h0000_0003);
    rdc(8'ha0, 32'h0000_0005);
    pins(32'h0000_0001);
    rdc(8'h00, 32'h0000_0010);
    rdc(8'h84, 32'h0000_000f);
    rdc(8'h7c, 32'h0000_000e);
    wr(8'h88, 32'h0000_0002);
    rdc(8'h84, 32'h0000_0000);
    rdc(8'h7c, 32'h0000_0006);
    // Masked event must not reach the pin
    wr(8'ha4, 32'h0000_0000);
    wr(8'h78, 32'h0000_0021);
    pins(32'h0000_0001);
    wr(8'h08, 32'h0000_0002);
    rdc(8'h84, 32'h0000_0000);
    wr(8'h70, 32'h0000_0000);
    // Transmit: one byte shifting, one queued
    wr(8'h00, 32'h0000_00a5);
    wr(8'h00, 32'h0000_005a);
    rdc(8'h80, 32'h0000_0001);
    rdc(8'h7c, 32'h0000_0003);
    wr(8'h88, 32'h0000_0004);
    rdc(8'h80, 32'h0000_0000);
    repeat (60) @(posedge clk);
    chk({24'h00_0000, serial_peer_inst.got_q}, 32'h0000_00a5);
    rdc(8'h7c, 32'h0000_0006);
    for (i = 0; i < 17; i = i + 1)
      wr(8'h00, 32'h0000_0030 + i);
    rdc(8'h80, 32'h0000_0010);
    rdc(8'h7c, 32'h0000_0001);
    wr(8'h08, 32'h0000_0004);
    rdc(8'h80, 32'h0000_0000);
    repeat (60) @(posedge clk);
    // Receive one frame from the far end
    serial_peer_inst.send(8'h3c);
    repeat (20) @(posedge clk);
    rdc(8'h84, 32'h0000_0001);
    rdc(8'h7c, 32'h0000_000e);
    rdc(8'h00, 32'h0000_003c);
    // Request-to-send storage seen from both offsets
    wr(8'h8c, 32'h0000_0001);
    rdc(8'h10, 32'h0000_0002);
    pins(32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
    rdc(8'h8c, 32'h0000_0000);
    wr(8'h10, 32'h0000_0002);
    rdc(8'h8c, 32'h0000_0001);
    // Port reset clears queues, enable and shadow
    wr(8'h70, 32'h0000_0001);
    wr(8'h78, 32'h0000_0077);
    wr(8'h00, 32'h0000_0011);
    wr(8'h88, 32'h0000_0001);
    repeat (8) @(posedge clk);
    rdc(8'h8c, 32'h0000_0000);
    rdc(8'h70, 32'h0000_0000);
    rdc(8'h84, 32'h0000_0000);
    rdc(8'h80, 32'h0000_0000);
    rdc(8'h7c, 32'h0000_0006);
    pins(32'h0000_0001);
    end_sim;
  end
endmodule
